/* File: bench/low_rate_processor_model.sv */
`timescale 1ns/100ps

// Register-bus master standing in for the low-rate processor. Each channel
// is held until its own ready is sampled high at a rising edge.
module low_rate_processor_model (
    input wire logic aclk,
    output logic [31:0] awaddr = 32'h0,
    output logic awvalid = 1'h0,
    input wire logic awready,
    output logic [31:0] wdata = 32'h0,
    output logic [3:0] wstrb = 4'h0,
    output logic wvalid = 1'h0,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready = 1'h0,
    output logic [31:0] araddr = 32'h0,
    output logic arvalid = 1'h0,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready = 1'h0
);
    int hangs = 0;

    // One whole command word per write, blocks far below the limit.
    // Handshakes are judged at the rising edge, before the flops move.
    task automatic wr(input logic [31:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [1:0] resp);
        int n;
        logic b_hs;
        n = 0;
        b_hs = 1'h0;
        resp = 2'h3;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (!b_hs && n < 50) begin
            @(posedge aclk);
            // Released lines show the inverse so stale values never match.
            if (awvalid && awready) begin
                awvalid <= 1'h0;
                awaddr <= ~a;
            end
            if (wvalid && wready) begin
                wvalid <= 1'h0;
                wdata <= ~d;
            end
            if (bvalid && bready) begin
                b_hs = 1'h1;
                resp = bresp;
            end
            n++;
        end
        bready <= 1'h0;
        // A stuck write is abandoned so later commands are not blocked.
        if (!b_hs) begin
            hangs++;
            awvalid <= 1'h0;
            wvalid <= 1'h0;
        end
    endtask

    // Single read; rready stays up until the data has been sampled.
    task automatic rd(input logic [31:0] a, output logic [31:0] d,
                      output logic [1:0] resp);
        int n;
        logic r_hs;
        n = 0;
        r_hs = 1'h0;
        d = 32'hFFFFFFFF;
        resp = 2'h3;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        while (!r_hs && n < 50) begin
            @(posedge aclk);
            if (arvalid && arready) begin
                arvalid <= 1'h0;
                araddr <= ~a;
            end
            if (rvalid && rready) begin
                r_hs = 1'h1;
                d = rdata;
                resp = rresp;
            end
            n++;
        end
        rready <= 1'h0;
        if (!r_hs) begin
            hangs++;
            arvalid <= 1'h0;
        end
    endtask
endmodule

/* File: bench/test_receiver_command_decoder.sv */
`timescale 1ns/100ps
`include "rx_cmd_cfg.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end

module test_receiver_command_decoder;
    localparam logic [15:0] VER = 16'h0A5C; // Arbitrary value.
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [31:0] awaddr, wdata, araddr, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, resp;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic start_analysis, start_fast, start_cal, fast_upper_band_two;
    logic [4:0] band_select, exp_band;
    logic [7:0] dev_value, exp_dev;
    logic [2:0] dev_strobe;
    logic [5:0] seen, p;
    logic [15:0] w;
    logic exp_ub2;
    int failures = 0;
    int cmp_count = 0;
    // Command word beside {analysis, fast, calibration, sounder strobe}.
    logic [21:0] rows [20] = '{
        {16'hE01F, 6'h20}, {16'hE015, 6'h20}, {16'h0000, 6'h00},
        {16'hE11F, 6'h08}, {16'hE10A, 6'h08}, {16'h00FF, 6'h00},
        {16'hE020, 6'h10}, {16'hE028, 6'h10}, {16'hE030, 6'h10},
        {16'hE038, 6'h10}, {16'h0100, 6'h00}, {16'h02AB, 6'h01},
        {16'h0355, 6'h02}, {16'h0401, 6'h03}, {16'h05C3, 6'h04},
        {16'h0600, 6'h00}, {16'h0700, 6'h00}, {16'h2000, 6'h00},
        {16'hE200, 6'h00}, {16'hFFFF, 6'h00}};

    receiver_command_decoder #(.FW_VERSION(VER)) u_receiver_command_decoder (
        .aclk, .aresetn,
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .start_analysis, .start_fast, .start_cal, .band_select,
        .fast_upper_band_two, .dev_value, .dev_strobe);

    low_rate_processor_model u_low_rate_processor_model (
        .aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
        .rdata, .rresp, .rvalid, .rready);

    initial begin
        forever #10 aclk = ~aclk;
    end

    // Pulses stand only in the response cycle, so catch them there.
    always @(negedge aclk) begin
        if (bvalid === 1'h1)
            seen <= {start_analysis, start_fast, start_cal, dev_strobe};
    end

    task automatic put(input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        u_low_rate_processor_model.wr({24'h0, a}, d, s, resp);
    endtask

    task automatic get(input logic [7:0] a);
        u_low_rate_processor_model.rd({24'h0, a}, rd, resp);
    endtask

    task automatic stop_test;
        failures += u_low_rate_processor_model.hangs;
        $display("Comparisons %0d, failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // A hang anywhere still ends in the closing report.
    initial begin
        #1ms;
        failures++;
        stop_test();
    end

    initial begin
        exp_band = 5'h00;
        exp_dev = 8'h00;
        exp_ub2 = 1'h0;
        // No command goes out while the receiver is still held idle.
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        @(negedge aclk);
        `CHK("reset outs", 21'h0, {seen[5:0] & 6'h0, start_analysis, start_fast, start_cal, dev_strobe, band_select, dev_value})
        `CHK("awready", 1'h1, awready)
        // Ordinary commands, back to back; levels must persist otherwise.
        foreach (rows[i]) begin
            w = rows[i][21:6];
            p = rows[i][5:0];
            put(`OFF_CMD, {16'h0000, w}, 4'h3);
            if (p[5] || p[3]) exp_band = w[4:0];
            if (p[4]) exp_ub2 = w[4] && !w[3];
            if (p[2:0] != 3'h0) exp_dev = w[7:0];
            `CHK("bresp", 2'h0, resp)
            `CHK("pulses", p, seen)
            `CHK("band_select", exp_band, band_select)
            `CHK("upper_two", exp_ub2, fast_upper_band_two)
            `CHK("dev_value", exp_dev, dev_value)
        end
        get(`OFF_VERSION);
        `CHK("version", {16'h0000, VER}, rd)
        get(`OFF_STATUS);
        `CHK("test mode on", 1'h1, rd[5])
        put(`OFF_CMD, 32'h0000_0600, 4'h3);
        get(`OFF_STATUS);
        `CHK("test mode off", 1'h0, rd[5])
        // Oversized buffer: commands are dropped until a legal length.
        put(`OFF_CTRL, 32'h0000_0080, 4'hF);
        get(`OFF_CTRL);
        `CHK("over limit", 1'h1, rd[8])
        put(`OFF_CMD, 32'h0000_E01F, 4'h3);
        `CHK("dropped", 6'h00, seen)
        get(`OFF_STATUS);
        `CHK("discard action", 4'h6, rd[3:0])
        put(`OFF_CTRL, {24'h0, `MAX_BUF_BYTES}, 4'hF);
        put(`OFF_CMD, 32'h0000_E001, 4'h3);
        `CHK("at limit", 6'h20, seen)
        `CHK("band at limit", 5'h01, band_select)
        // Unmapped read and a partial command write are refused.
        get(8'h40);
        `CHK("unmapped resp", 2'h2, resp)
        `CHK("unmapped data", 32'h0, rd)
        put(`OFF_CMD, 32'h0000_E01F, 4'h1);
        `CHK("strobe resp", 2'h2, resp)
        `CHK("strobe pulses", 6'h00, seen)
        // Second reset in mid-run clears the held levels.
        @(posedge aclk);
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        @(negedge aclk);
        `CHK("levels", 14'h0, {band_select, fast_upper_band_two, dev_value})
        stop_test();
    end
endmodule

/* File: include/rx_cmd_cfg.svh */
`ifndef RX_CMD_CFG_SVH
`define RX_CMD_CFG_SVH
`define OFF_CMD 8'h00
`define OFF_CTRL 8'h04
`define OFF_STATUS 8'h08
`define OFF_RESULT 8'h0C
`define OFF_VERSION 8'h10
`define OFF_SETTINGS 8'h14
`define MAJOR_MSB 15
`define MAJOR_LSB 13
`define SUB_MSB 12
`define SUB_LSB 8
`define FAST_BIT 5
`define UB1_BIT 3
`define UB2_BIT 4
`define BAND_MSB 4
`define MAX_BUF_BYTES 8'h7F
`define RST_SETTINGS 8'h00
`endif

/* File: include/rx_cmd_pkg.sv */
package rx_cmd_pkg;
    typedef enum logic [2:0] {
        MAJ_DEV = 3'h0,
        MAJ_MEAS = 3'h7
    } major_type;
    typedef enum logic [4:0] {
        SUB_NOP = 5'h00,
        SUB_VERSION = 5'h01,
        SUB_STEP = 5'h02,
        SUB_SWITCH = 5'h03,
        SUB_START = 5'h04,
        SUB_BAND = 5'h05,
        SUB_TEST = 5'h06
    } sub_type;
    // Measurement subtypes reuse the low codes, so they need their own type.
    typedef enum logic [4:0] {
        SUB_ANALYSIS = 5'h00,
        SUB_CAL = 5'h01
    } meas_sub_type;
    typedef enum logic [3:0] {
        ACT_NONE = 4'h0,
        ACT_ANALYSIS = 4'h1,
        ACT_FAST = 4'h2,
        ACT_CAL = 4'h3,
        ACT_VERSION = 4'h4,
        ACT_DEV = 4'h5,
        ACT_DISCARD = 4'h6
    } action_type;
endpackage

/* File: logic/receiver_command_decoder.sv */
`timescale 1ns/100ps
`include "rx_cmd_cfg.svh"

module receiver_command_decoder #(
    parameter logic [15:0] FW_VERSION = 16'h0123 // Arbitrary value.
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic start_analysis,
    output logic start_fast,
    output logic start_cal,
    output logic [4:0] band_select,
    output logic fast_upper_band_two,
    output logic [7:0] dev_value,
    output logic [2:0] dev_strobe
);

    logic [31:0] awaddr_ff, nxt_awaddr;
    logic aw_ok_ff, nxt_aw_ok;
    logic [31:0] wdata_ff, nxt_wdata;
    logic [3:0] wstrb_ff, nxt_wstrb;
    logic w_ok_ff, nxt_w_ok;
    logic bvalid_ff, nxt_bvalid;
    logic [1:0] bresp_ff, nxt_bresp;
    logic rvalid_ff, nxt_rvalid;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [1:0] rresp_ff, nxt_rresp;
    logic [7:0] buf_len_ff, nxt_buf_len;
    logic buf_bad_ff, nxt_buf_bad;
    logic [3:0] last_act_ff, nxt_last_act;
    logic [15:0] last_word_ff, nxt_last_word;
    logic [7:0] cmd_count_ff, nxt_cmd_count;
    logic [7:0] discard_count_ff, nxt_discard_count;
    logic [15:0] version_ff, nxt_version;
    logic version_valid_ff, nxt_version_valid;
    logic test_mode_ff, nxt_test_mode;
    logic ana_ff, nxt_ana;
    logic fast_ff, nxt_fast;
    logic cal_ff, nxt_cal;
    logic [4:0] band_ff, nxt_band;
    logic ub2_ff, nxt_ub2;
    logic [7:0] dev_val_ff, nxt_dev_val;
    logic [2:0] dev_stb_ff, nxt_dev_stb;
    logic wr_fire;
    logic [15:0] cmd;
    logic [2:0] major;
    logic [4:0] sub;
    logic [7:0] param;

    // The write fires once both address and data are held.
    assign wr_fire = aw_ok_ff && w_ok_ff && !bvalid_ff;
    assign cmd = wdata_ff[15:0];
    assign major = cmd[`MAJOR_MSB:`MAJOR_LSB];
    assign sub = cmd[`SUB_MSB:`SUB_LSB];
    assign param = cmd[7:0];

    assign s_axi_awready = !aw_ok_ff && !bvalid_ff;
    assign s_axi_wready = !w_ok_ff && !bvalid_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign start_analysis = ana_ff;
    assign start_fast = fast_ff;
    assign start_cal = cal_ff;
    assign band_select = band_ff;
    assign fast_upper_band_two = ub2_ff;
    assign dev_value = dev_val_ff;
    assign dev_strobe = dev_stb_ff;

    // Write channel capture, command decode and the buffer length guard.
    // Writing CTRL opens a new buffer with its byte length; commands of a
    // buffer over the limit are counted as discarded and never executed.
    always_comb begin
        nxt_awaddr = awaddr_ff;
        nxt_aw_ok = aw_ok_ff;
        nxt_wdata = wdata_ff;
        nxt_wstrb = wstrb_ff;
        nxt_w_ok = w_ok_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        nxt_buf_len = buf_len_ff;
        nxt_buf_bad = buf_bad_ff;
        nxt_last_act = last_act_ff;
        nxt_last_word = last_word_ff;
        nxt_cmd_count = cmd_count_ff;
        nxt_discard_count = discard_count_ff;
        nxt_version = version_ff;
        nxt_version_valid = version_valid_ff;
        nxt_test_mode = test_mode_ff;
        nxt_ana = 1'b0;
        nxt_fast = 1'b0;
        nxt_cal = 1'b0;
        nxt_band = band_ff;
        nxt_ub2 = ub2_ff;
        nxt_dev_val = dev_val_ff;
        nxt_dev_stb = 3'h0;
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_awaddr = s_axi_awaddr;
            nxt_aw_ok = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_wdata = s_axi_wdata;
            nxt_wstrb = s_axi_wstrb;
            nxt_w_ok = 1'b1;
        end
        if (bvalid_ff && s_axi_bready) begin
            nxt_bvalid = 1'b0;
        end
        if (wr_fire) begin
            nxt_aw_ok = 1'b0;
            nxt_w_ok = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = 2'h0;
            if (awaddr_ff[7:0] == `OFF_CTRL) begin
                // Signed 8-bit length: anything above 127 is negative.
                nxt_buf_len = wdata_ff[7:0];
                nxt_buf_bad = wdata_ff[7];
            end else if (awaddr_ff[7:0] == `OFF_CMD) begin
                if (wstrb_ff[1:0] != 2'h3) begin
                    nxt_bresp = 2'h2;
                end else if (buf_bad_ff) begin
                    nxt_last_act = rx_cmd_pkg::ACT_DISCARD;
                    nxt_discard_count = discard_count_ff + 8'h01;
                end else begin
                    nxt_cmd_count = cmd_count_ff + 8'h01;
                    nxt_last_word = cmd;
                    nxt_last_act = rx_cmd_pkg::ACT_NONE;
                    if (major == rx_cmd_pkg::MAJ_MEAS) begin
                        if (sub == rx_cmd_pkg::SUB_ANALYSIS) begin
                            // Only the band mask travels; modes stay stored.
                            if (param[`FAST_BIT]) begin
                                nxt_fast = 1'b1;
                                nxt_ub2 = param[`UB2_BIT] &&
                                    !param[`UB1_BIT];
                                nxt_last_act = rx_cmd_pkg::ACT_FAST;
                            end else begin
                                nxt_ana = 1'b1;
                                nxt_band = param[`BAND_MSB:0];
                                nxt_last_act = rx_cmd_pkg::ACT_ANALYSIS;
                            end
                        end else if (sub == rx_cmd_pkg::SUB_CAL) begin
                            nxt_cal = 1'b1;
                            nxt_band = param[`BAND_MSB:0];
                            nxt_last_act = rx_cmd_pkg::ACT_CAL;
                        end
                    end else if (major == rx_cmd_pkg::MAJ_DEV) begin
                        if (sub == rx_cmd_pkg::SUB_VERSION) begin
                            nxt_version = FW_VERSION;
                            nxt_version_valid = 1'b1;
                            nxt_last_act = rx_cmd_pkg::ACT_VERSION;
                        end else if (sub == rx_cmd_pkg::SUB_TEST) begin
                            nxt_test_mode = !test_mode_ff;
                            nxt_last_act = rx_cmd_pkg::ACT_DEV;
                        end else if (sub >= rx_cmd_pkg::SUB_STEP &&
                            sub <= rx_cmd_pkg::SUB_BAND) begin
                            // Step, switch, start and band: code - 1.
                            nxt_dev_val = param;
                            nxt_dev_stb = 3'(sub - rx_cmd_pkg::SUB_STEP)
                                + 3'h1;
                            nxt_last_act = rx_cmd_pkg::ACT_DEV;
                        end
                        // No-op and undefined subtypes change only the count, last word and action.
                    end
                end
            end else if (awaddr_ff[7:0] != `OFF_VERSION) begin
                nxt_bresp = 2'h2;
            end
        end
    end

    // Read channel: one cycle from address to data.
    always_comb begin
        nxt_rvalid = rvalid_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        if (rvalid_ff && s_axi_rready) begin
            nxt_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            nxt_rvalid = 1'b1;
            nxt_rresp = 2'h0;
            if (s_axi_araddr[7:0] == `OFF_STATUS) begin
                nxt_rdata = {16'h0000, discard_count_ff, 2'h0,
                    test_mode_ff, version_valid_ff, last_act_ff};
            end else if (s_axi_araddr[7:0] == `OFF_RESULT) begin
                nxt_rdata = {8'h00, cmd_count_ff, last_word_ff};
            end else if (s_axi_araddr[7:0] == `OFF_VERSION) begin
                nxt_rdata = {16'h0000, version_ff};
            end else if (s_axi_araddr[7:0] == `OFF_CTRL) begin
                nxt_rdata = {23'h000000, buf_bad_ff, buf_len_ff};
            end else if (s_axi_araddr[7:0] == `OFF_SETTINGS) begin
                nxt_rdata = {16'h0000, dev_val_ff, 2'h0, ub2_ff, band_ff};
            end else begin
                nxt_rdata = 32'h00000000;
                nxt_rresp = 2'h2;
            end
        end
    end

    // Register stage; synchronous reset returns every flop to idle.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awaddr_ff <= 32'h00000000;
            aw_ok_ff <= 1'b0;
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
            w_ok_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= 2'h0;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= 2'h0;
            buf_len_ff <= 8'h00;
            buf_bad_ff <= 1'b0;
            last_act_ff <= 4'h0;
            last_word_ff <= 16'h0000;
            cmd_count_ff <= 8'h00;
            discard_count_ff <= 8'h00;
            version_ff <= 16'h0000;
            version_valid_ff <= 1'b0;
            test_mode_ff <= 1'b0;
            ana_ff <= 1'b0;
            fast_ff <= 1'b0;
            cal_ff <= 1'b0;
            band_ff <= 5'h00;
            ub2_ff <= 1'b0;
            dev_val_ff <= `RST_SETTINGS;
            dev_stb_ff <= 3'h0;
        end else begin
            awaddr_ff <= nxt_awaddr;
            aw_ok_ff <= nxt_aw_ok;
            wdata_ff <= nxt_wdata;
            wstrb_ff <= nxt_wstrb;
            w_ok_ff <= nxt_w_ok;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
            buf_len_ff <= nxt_buf_len;
            buf_bad_ff <= nxt_buf_bad;
            last_act_ff <= nxt_last_act;
            last_word_ff <= nxt_last_word;
            cmd_count_ff <= nxt_cmd_count;
            discard_count_ff <= nxt_discard_count;
            version_ff <= nxt_version;
            version_valid_ff <= nxt_version_valid;
            test_mode_ff <= nxt_test_mode;
            ana_ff <= nxt_ana;
            fast_ff <= nxt_fast;
            cal_ff <= nxt_cal;
            band_ff <= nxt_band;
            ub2_ff <= nxt_ub2;
            dev_val_ff <= nxt_dev_val;
            dev_stb_ff <= nxt_dev_stb;
        end
    end

    // Checks tie each pulse to the command word that caused it.
    property p_analysis;
        @(posedge aclk) disable iff (!aresetn)
        start_analysis |-> $past(major) == 3'h7 && $past(sub) == 5'h00
            && !$past(param[5]) && band_select == $past(param[4:0]);
    endproperty
    a_analysis: assert property (p_analysis)
        else $error("analysis pulse without matching command");
    property p_fast_band;
        @(posedge aclk) disable iff (!aresetn)
        start_fast |-> fast_upper_band_two ==
            ($past(param[4]) && !$past(param[3]));
    endproperty
    a_fast_band: assert property (p_fast_band)
        else $error("fast mode band choice wrong");
    property p_fast_only;
        @(posedge aclk) disable iff (!aresetn)
        start_fast |-> !start_analysis && $past(param[5]);
    endproperty
    a_fast_only: assert property (p_fast_only)
        else $error("fast mode without bit five");
    property p_cal;
        @(posedge aclk) disable iff (!aresetn)
        start_cal |-> $past(cmd[15:8]) == 8'hE1
            && band_select == $past(param[4:0]);
    endproperty
    a_cal: assert property (p_cal)
        else $error("calibration pulse without command");
    property p_discard;
        @(posedge aclk) disable iff (!aresetn)
        buf_bad_ff |-> !(start_analysis || start_fast || start_cal)
            && dev_strobe == 3'h0 || !$past(buf_bad_ff);
    endproperty
    a_discard: assert property (p_discard)
        else $error("command ran from an oversized buffer");
    property p_version;
        @(posedge aclk) disable iff (!aresetn)
        wr_fire && !buf_bad_ff && awaddr_ff[7:0] == 8'h00
            && cmd[15:8] == 8'h01 |=> version_ff == FW_VERSION;
    endproperty
    a_version: assert property (p_version)
        else $error("version not returned");
    property p_nop;
        @(posedge aclk) disable iff (!aresetn)
        wr_fire && awaddr_ff[7:0] == 8'h00 && cmd[15:8] == 8'h00
            |=> $stable(band_ff) && !start_analysis && !start_cal
            && dev_strobe == 3'h0 && $stable(test_mode_ff);
    endproperty
    a_nop: assert property (p_nop)
        else $error("no-operation changed state");
    property p_undef;
        @(posedge aclk) disable iff (!aresetn)
        wr_fire && awaddr_ff[7:0] == 8'h00 && (cmd[15:8] == 8'h07 ||
            (cmd[15:13] != 3'h0 && cmd[15:13] != 3'h7)
            || cmd[15:8] == 8'hE2) |=> $stable(band_ff) && !start_fast
            && !start_cal
            && !start_analysis && dev_strobe == 3'h0;
    endproperty
    a_undef: assert property (p_undef)
        else $error("undefined command had an effect");
    property p_dev;
        @(posedge aclk) disable iff (!aresetn)
        dev_strobe != 3'h0 |-> $past(cmd[15:11]) == 5'h00
            && dev_strobe == $past(cmd[10:8]) - 3'h1;
    endproperty
    a_dev: assert property (p_dev)
        else $error("sounder strobe mismatched");
    c_analysis: cover property (@(posedge aclk) start_analysis);
    c_fast: cover property (@(posedge aclk) start_fast);
    c_cal: cover property (@(posedge aclk) start_cal);
    c_discard: cover property (@(posedge aclk)
        last_act_ff == 4'h6);

endmodule
